// ### core/scsb_pkg.sv
// Purpose: Constants for the system control and status register bank
// Assumes: Byte-wide registers on an on-chip processor-style byte port
// Notes: Addresses are the processor byte addresses
package scsb_pkg;
  localparam int unsigned SCSB_AW = 32;
  localparam int unsigned SCSB_DW = 8;
  localparam logic [31:0] SCSB_ADDR_RAM_STATUS = 32'h40000503;
  localparam logic [31:0] SCSB_ADDR_CLK = 32'h40000504;
  localparam logic [31:0] SCSB_ADDR_IF_CTRL = 32'h40000506;
  localparam logic [31:0] SCSB_ADDR_ERR_LO = 32'h40000508;
  localparam logic [31:0] SCSB_ADDR_ERR_HI = 32'h40000509;
  // Status bit positions
  localparam int unsigned SCSB_B_DRAM_DONE = 0;
  localparam int unsigned SCSB_B_DRAM_FAIL = 1;
  localparam int unsigned SCSB_B_PRAM_DONE = 4;
  localparam int unsigned SCSB_B_PRAM_FAIL = 5;
  // Clock register fields
  localparam int unsigned SCSB_B_CLK_SEL_LO = 0;
  localparam int unsigned SCSB_B_CLK_STS_LO = 4;
  localparam logic [1:0] SCSB_CLK_SEL_RST = 2'h0;
  // Interface control bits
  localparam int unsigned SCSB_B_SPI_EN = 0;
  localparam int unsigned SCSB_B_I2C_EN = 1;
  localparam int unsigned SCSB_B_OW_EN = 2;
  localparam int unsigned SCSB_B_OW_XCVR = 3;
  localparam int unsigned SCSB_B_OW_DGL = 4;
  localparam int unsigned SCSB_B_I2C_RATE = 5;
  localparam int unsigned SCSB_B_I2C_DGL = 6;
  localparam logic [6:0] SCSB_IF_CTRL_MASK = 7'h7F;
  localparam logic [6:0] SCSB_IF_CTRL_RST = 7'h47;
  // Upper error register
  localparam int unsigned SCSB_B_ERR_CLR = 7;
  localparam int unsigned SCSB_ERR_N = 8;
  // Processor frequency codes
  typedef enum logic [1:0] {
    SCSB_F_1MHZ = 2'b00,
    SCSB_F_2MHZ = 2'b01,
    SCSB_F_4MHZ = 2'b10,
    SCSB_F_500KHZ = 2'b11
  } scsb_freq_e;
  // Deglitch windows in ms and clock cycles at 100 MHz
  localparam int unsigned SCSB_CLK_MHZ = 100;
  localparam int unsigned SCSB_DGL_SHORT_MS = 1;
  localparam int unsigned SCSB_DGL_LONG_MS = 10;
  localparam int unsigned SCSB_DGL_SHORT_CYC = SCSB_DGL_SHORT_MS * 1000 * SCSB_CLK_MHZ;
  localparam int unsigned SCSB_DGL_LONG_CYC = SCSB_DGL_LONG_MS * 1000 * SCSB_CLK_MHZ;
endpackage

// ### core/scsb_err_flags.sv
// Purpose: Sticky one-wire error flags with a shared clear
// Assumes: Error events are one-cycle pulses from the one-wire receiver
// Notes: A set arriving with the clear wins, so no event is lost
`timescale 1ns/1ps
`default_nettype none
module scsb_err_flags
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic clear_in,
  input wire logic [scsb_pkg::SCSB_ERR_N-1:0] event_in,
  output logic [scsb_pkg::SCSB_ERR_N-1:0] flags_out
);
  import scsb_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < SCSB_ERR_N; gi++)
    begin : g_flag
      logic flag_ff;
      always_ff @(posedge sys_clk_in)
      begin
        if (srst_in)
          flag_ff <= 1'b0;
        else if (ce_in)
        begin
          if (event_in[gi])
            flag_ff <= 1'b1;
          else if (clear_in)
            flag_ff <= 1'b0;
        end
      end
      assign flags_out[gi] = flag_ff;
    end
  endgenerate
endmodule // scsb_err_flags
`default_nettype wire

// ### core/scsb_bank.sv
// Purpose: System control and status register bank
// Assumes: Byte access with address, write strobe, read strobe, one-cycle read latency
// Notes: Self-test engines and one-wire receiver sit outside and report by pulses
// Notes on behaviour
// - Data RAM test done bit 0 set on completion, zero before and during test.
// - Data RAM test failure at bit 1; valid only with done set.
// - Program RAM test done bit 4 set on completion, zero otherwise.
// - Program RAM test failure at bit 5; valid only with done set.
// - Clock select bits 1:0: 1, 2, 4 MHz, 500 kHz; resets 00.
// - Read-only clock status bits 5:4 report frequency in effect.
// - SPI, I2C, one-wire enables at bits 0..2, reset one.
// - Bit 3 connects one-wire transceiver to supply; resets zero.
// - Bit 4 picks 10 ms or 1 ms one-wire deglitch; resets zero.
// - Bit 5 selects fast I2C above 400 kbit/s; resets zero.
// - Bit 6 enables I2C deglitch filters; resets one.
// - Error 0 set when sync rate below 320 bit/s less 5%.
// - Error 1 set when sync rate above 19200 bit/s plus 5%.
// - Error 2 set when sync stop bit too short.
// - Errors 3 and 4: command stop bit wrong value, too short.
// - Errors 5 and 6: data stop bit wrong value, too short.
// - Error 7 set when our stop bit is overdriven dominant.
// - Writing one to upper error bit 7 clears the lower error register flags.
`timescale 1ns/1ps
`default_nettype none
module scsb_bank
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [scsb_pkg::SCSB_AW-1:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [scsb_pkg::SCSB_DW-1:0] wdata_in,
  output logic [scsb_pkg::SCSB_DW-1:0] rdata_out,
  output logic rvalid_out,
  input wire logic data_ram_test_start_in,
  input wire logic data_ram_test_done_in,
  input wire logic data_ram_test_fail_in,
  input wire logic program_ram_test_start_in,
  input wire logic program_ram_test_done_in,
  input wire logic program_ram_test_fail_in,
  input wire logic [1:0] clk_in_effect_in,
  input wire logic sync_rate_low_error_in,
  input wire logic sync_rate_high_error_in,
  input wire logic sync_stop_short_error_in,
  input wire logic command_stop_value_error_in,
  input wire logic command_stop_short_error_in,
  input wire logic data_stop_value_error_in,
  input wire logic data_stop_short_error_in,
  input wire logic stop_bit_overdrive_error_in,
  output logic [1:0] clk_select_out,
  output logic spi_enable_out,
  output logic i2c_enable_out,
  output logic one_wire_enable_out,
  output logic one_wire_transceiver_enable_out,
  output logic one_wire_deglitch_select_out,
  output logic i2c_fast_rate_out,
  output logic i2c_deglitch_enable_out,
  output logic [31:0] one_wire_deglitch_cycles_out
);
  import scsb_pkg::*;

  logic [1:0] clk_sel_ff;
  logic [1:0] clk_sts_ff;
  logic [6:0] if_ctrl_ff;
  logic dram_done_ff;
  logic dram_fail_ff;
  logic pram_done_ff;
  logic pram_fail_ff;
  logic [SCSB_DW-1:0] rdata_ff;
  logic rvalid_ff;
  logic [31:0] dgl_cyc_ff;
  logic [SCSB_ERR_N-1:0] err_flags;
  logic [SCSB_ERR_N-1:0] err_events;
  logic err_clear;
  logic [SCSB_DW-1:0] nxt_rdata;

  wire wr_clk = wr_in && (addr_in == SCSB_ADDR_CLK);
  wire wr_if = wr_in && (addr_in == SCSB_ADDR_IF_CTRL);

  // Clock select, bits above the field dropped
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      clk_sel_ff <= SCSB_CLK_SEL_RST;
    else if (ce_in && wr_clk)
      clk_sel_ff <= wdata_in[SCSB_B_CLK_SEL_LO +: 2];
  end

  // Status follows the clock generator, not the request, so a switch in flight shows
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      clk_sts_ff <= SCSB_CLK_SEL_RST;
    else if (ce_in)
      clk_sts_ff <= clk_in_effect_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      if_ctrl_ff <= SCSB_IF_CTRL_RST;
    else if (ce_in && wr_if)
      if_ctrl_ff <= wdata_in[6:0] & SCSB_IF_CTRL_MASK;
  end

  // Deglitch window in cycles for the one-wire activation filter
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      dgl_cyc_ff <= 32'(SCSB_DGL_SHORT_CYC);
    else if (ce_in)
      dgl_cyc_ff <= if_ctrl_ff[SCSB_B_OW_DGL] ? 32'(SCSB_DGL_LONG_CYC)
                                              : 32'(SCSB_DGL_SHORT_CYC);
  end

  // Self-test status: start clears, done sets; fail only latched at done
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      dram_done_ff <= 1'b0;
      dram_fail_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (data_ram_test_done_in)
      begin
        dram_done_ff <= 1'b1;
        dram_fail_ff <= data_ram_test_fail_in;
      end
      else if (data_ram_test_start_in)
      begin
        dram_done_ff <= 1'b0;
        dram_fail_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      pram_done_ff <= 1'b0;
      pram_fail_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      if (program_ram_test_done_in)
      begin
        pram_done_ff <= 1'b1;
        pram_fail_ff <= program_ram_test_fail_in;
      end
      else if (program_ram_test_start_in)
      begin
        pram_done_ff <= 1'b0;
        pram_fail_ff <= 1'b0;
      end
    end
  end

  assign err_events = {stop_bit_overdrive_error_in,
                       data_stop_short_error_in, data_stop_value_error_in,
                       command_stop_short_error_in, command_stop_value_error_in,
                       sync_stop_short_error_in,
                       sync_rate_high_error_in,
                       sync_rate_low_error_in};
  assign err_clear = wr_in && (addr_in == SCSB_ADDR_ERR_HI) && wdata_in[SCSB_B_ERR_CLR];

  scsb_err_flags u_err (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .clear_in(err_clear),
    .event_in(err_events),
    .flags_out(err_flags)
  );

  // Read mux; unmapped and write-only locations read zero
  always_comb
  begin
    nxt_rdata = '0;
    case (addr_in)
      SCSB_ADDR_RAM_STATUS:
      begin
        nxt_rdata[SCSB_B_DRAM_DONE] = dram_done_ff;
        nxt_rdata[SCSB_B_DRAM_FAIL] = dram_fail_ff;
        nxt_rdata[SCSB_B_PRAM_DONE] = pram_done_ff;
        nxt_rdata[SCSB_B_PRAM_FAIL] = pram_fail_ff;
      end
      SCSB_ADDR_CLK:
      begin
        nxt_rdata[SCSB_B_CLK_SEL_LO +: 2] = clk_sel_ff;
        nxt_rdata[SCSB_B_CLK_STS_LO +: 2] = clk_sts_ff;
      end
      SCSB_ADDR_IF_CTRL:
        nxt_rdata = {1'b0, if_ctrl_ff};
      SCSB_ADDR_ERR_LO:
        nxt_rdata = err_flags;
      default:
        nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end
    else if (ce_in)
    begin
      rvalid_ff <= rd_in;
      if (rd_in)
        rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;
  assign rvalid_out = rvalid_ff;
  assign clk_select_out = clk_sel_ff;
  assign spi_enable_out = if_ctrl_ff[SCSB_B_SPI_EN];
  assign i2c_enable_out = if_ctrl_ff[SCSB_B_I2C_EN];
  assign one_wire_enable_out = if_ctrl_ff[SCSB_B_OW_EN];
  assign one_wire_transceiver_enable_out = if_ctrl_ff[SCSB_B_OW_XCVR];
  assign one_wire_deglitch_select_out = if_ctrl_ff[SCSB_B_OW_DGL];
  assign i2c_fast_rate_out = if_ctrl_ff[SCSB_B_I2C_RATE];
  assign i2c_deglitch_enable_out = if_ctrl_ff[SCSB_B_I2C_DGL];
  assign one_wire_deglitch_cycles_out = dgl_cyc_ff;

  // Assertions
  dram_done_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && data_ram_test_done_in |=> dram_done_ff)
    else $error("data ram done not set");
  dram_done_clr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && data_ram_test_start_in && !data_ram_test_done_in |=> !dram_done_ff)
    else $error("data ram done not cleared at start");
  dram_fail_cap_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && data_ram_test_done_in |=> dram_fail_ff == $past(data_ram_test_fail_in))
    else $error("data ram fail not captured");
  pram_done_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && program_ram_test_done_in |=> pram_done_ff)
    else $error("program ram done not set");
  pram_fail_cap_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && program_ram_test_done_in |=> pram_fail_ff == $past(program_ram_test_fail_in))
    else $error("program ram fail not captured");
  clk_sel_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_clk |=> clk_select_out == $past(wdata_in[1:0]))
    else $error("clock select write lost");
  clk_sts_track_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in |=> clk_sts_ff == $past(clk_in_effect_in))
    else $error("clock status stale");
  if_ctrl_reset_a: assert property (@(posedge sys_clk_in)
    srst_in |=> spi_enable_out && i2c_enable_out && one_wire_enable_out
      && i2c_deglitch_enable_out && !one_wire_transceiver_enable_out)
    else $error("interface control reset wrong");
  xcvr_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> one_wire_transceiver_enable_out == $past(wdata_in[3]))
    else $error("transceiver enable write lost");
  dgl_window_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && one_wire_deglitch_select_out ##1 ce_in
      |-> one_wire_deglitch_cycles_out == 32'(SCSB_DGL_LONG_CYC))
    else $error("deglitch window wrong");
  i2c_rate_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> i2c_fast_rate_out == $past(wdata_in[5]))
    else $error("i2c rate write lost");
  i2c_dgl_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> i2c_deglitch_enable_out == $past(wdata_in[6]))
    else $error("i2c deglitch write lost");
  err_sticky_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && sync_rate_low_error_in |=> err_flags[0])
    else $error("sync low error not latched");
  err_high_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && sync_rate_high_error_in |=> err_flags[1])
    else $error("sync high error not latched");
  err_overdrive_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && stop_bit_overdrive_error_in |=> err_flags[7])
    else $error("overdrive error not latched");
  err_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && err_clear && err_events == '0 |=> err_flags == '0)
    else $error("error clear failed");
  err_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !err_clear && err_flags[3] |=> err_flags[3])
    else $error("error flag dropped without clear");
  if_reserved_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && rd_in && addr_in == SCSB_ADDR_IF_CTRL |=> rdata_out[7] == 1'b0)
    else $error("reserved bit reads one");

  // Every event line latches its own flag
  err_sync_stop_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && sync_stop_short_error_in |=> err_flags[2])
    else $error("sync stop error not latched");
  err_cmd_value_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && command_stop_value_error_in |=> err_flags[3])
    else $error("command stop value error not latched");
  err_cmd_short_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && command_stop_short_error_in |=> err_flags[4])
    else $error("command stop short error not latched");
  err_data_value_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && data_stop_value_error_in |=> err_flags[5])
    else $error("data stop value error not latched");
  err_data_short_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && data_stop_short_error_in |=> err_flags[6])
    else $error("data stop short error not latched");
  err_clear_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && err_clear |=> err_flags == $past(err_events))
    else $error("clear and event in one cycle mishandled");
  err_read_only_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_in && addr_in == SCSB_ADDR_ERR_LO && err_events == '0
      |=> err_flags == $past(err_flags))
    else $error("error flags changed by a write");
  err_no_spur_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && !err_events[0] && !err_flags[0] |=> !err_flags[0])
    else $error("error flag set without event");

  // Start of a test hides stale results
  dram_fail_clr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && data_ram_test_start_in && !data_ram_test_done_in |=> !dram_fail_ff)
    else $error("data ram fail not cleared at start");
  pram_done_clr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && program_ram_test_start_in && !program_ram_test_done_in |=> !pram_done_ff)
    else $error("program ram done not cleared at start");
  pram_fail_clr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && program_ram_test_start_in && !program_ram_test_done_in |=> !pram_fail_ff)
    else $error("program ram fail not cleared at start");

  // Interface bits follow a write; a frozen enable holds them
  spi_en_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> spi_enable_out == $past(wdata_in[SCSB_B_SPI_EN]))
    else $error("spi enable write lost");
  i2c_en_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> i2c_enable_out == $past(wdata_in[SCSB_B_I2C_EN]))
    else $error("i2c enable write lost");
  ow_en_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> one_wire_enable_out == $past(wdata_in[SCSB_B_OW_EN]))
    else $error("one wire enable write lost");
  dgl_sel_write_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && wr_if |=> one_wire_deglitch_select_out == $past(wdata_in[SCSB_B_OW_DGL]))
    else $error("deglitch select write lost");
  dgl_short_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && !one_wire_deglitch_select_out ##1 ce_in
      |-> one_wire_deglitch_cycles_out == 32'(SCSB_DGL_SHORT_CYC))
    else $error("short deglitch window wrong");
  if_freeze_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !ce_in |=> if_ctrl_ff == $past(if_ctrl_ff))
    else $error("interface control moved while frozen");

  // Reserved positions stay zero on every read
  clk_reserved_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && rd_in && addr_in == SCSB_ADDR_CLK |=> rdata_out[7:6] == 2'h0 && rdata_out[3:2] == 2'h0)
    else $error("clock register reserved bits set");
  ram_reserved_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && rd_in && addr_in == SCSB_ADDR_RAM_STATUS
      |=> rdata_out[7:6] == 2'h0 && rdata_out[3:2] == 2'h0)
    else $error("ram status reserved bits set");
  err_hi_zero_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    ce_in && rd_in && addr_in == SCSB_ADDR_ERR_HI |=> rdata_out == '0)
    else $error("upper error register not zero");
endmodule // scsb_bank
`default_nettype wire

// ### tb/scsb_bank_tb_top.sv
// Purpose: Self-checking bench for the system control and status register bank
// Assumes: Inputs driven at the falling edge, reads answered one cycle later
// Notes: Every strobe is followed by an idle cycle so no signal changes twice at once
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin fail_count++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (act), (exp)); end end
module scsb_bank_tb_top;
  import scsb_pkg::*;
  logic sys_clk_in;
  logic srst_in;
  logic ce_in;
  logic [31:0] addr_in;
  logic wr_in;
  logic rd_in;
  logic [7:0] wdata_in;
  logic [7:0] rdata_out;
  logic rvalid_out;
  logic dstart, ddone, dfail, pstart, pdone, pfail;
  logic [1:0] clk_in_effect_in;
  logic [7:0] ev;
  logic [1:0] clk_select_out;
  logic [6:0] ifo;
  logic [31:0] dgl_cyc;
  int fail_count = 0;
  int num_checks = 0;
  scsb_bank i_dut (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out),
    .data_ram_test_start_in(dstart), .data_ram_test_done_in(ddone),
    .data_ram_test_fail_in(dfail), .program_ram_test_start_in(pstart),
    .program_ram_test_done_in(pdone), .program_ram_test_fail_in(pfail),
    .clk_in_effect_in(clk_in_effect_in),
    .sync_rate_low_error_in(ev[0]), .sync_rate_high_error_in(ev[1]),
    .sync_stop_short_error_in(ev[2]), .command_stop_value_error_in(ev[3]),
    .command_stop_short_error_in(ev[4]), .data_stop_value_error_in(ev[5]),
    .data_stop_short_error_in(ev[6]), .stop_bit_overdrive_error_in(ev[7]),
    .clk_select_out(clk_select_out),
    .spi_enable_out(ifo[0]), .i2c_enable_out(ifo[1]), .one_wire_enable_out(ifo[2]),
    .one_wire_transceiver_enable_out(ifo[3]), .one_wire_deglitch_select_out(ifo[4]),
    .i2c_fast_rate_out(ifo[5]), .i2c_deglitch_enable_out(ifo[6]),
    .one_wire_deglitch_cycles_out(dgl_cyc)
  );
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    addr_in = a;
    wdata_in = d;
    wr_in = 1'b1;
    @(negedge sys_clk_in);
    wr_in = 1'b0;
    @(negedge sys_clk_in);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    addr_in = a;
    rd_in = 1'b1;
    @(negedge sys_clk_in);
    rd_in = 1'b0;
    `CHK(rvalid_out, 1'b1)
    `CHK(rdata_out, e)
    @(negedge sys_clk_in);
    `CHK(rvalid_out, 1'b0)
  endtask
  // One-cycle pulse on one or more error event lines
  task automatic pulse_ev(input logic [7:0] m);
    ev = m;
    @(negedge sys_clk_in);
    ev = 8'h00;
    @(negedge sys_clk_in);
  endtask
  task automatic ram_test(input bit prog, input logic f);
    if (prog)
      pstart = 1'b1;
    else
      dstart = 1'b1;
    @(negedge sys_clk_in);
    pstart = 1'b0;
    dstart = 1'b0;
    @(negedge sys_clk_in);
    if (prog)
    begin
      pdone = 1'b1;
      pfail = f;
    end
    else
    begin
      ddone = 1'b1;
      dfail = f;
    end
    @(negedge sys_clk_in);
    pdone = 1'b0;
    ddone = 1'b0;
    pfail = 1'b0;
    dfail = 1'b0;
    @(negedge sys_clk_in);
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    fail_count++;
    give_verdict();
  end
  initial
  begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    addr_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    wdata_in = 8'h00;
    dstart = 1'b0;
    ddone = 1'b0;
    dfail = 1'b0;
    pstart = 1'b0;
    pdone = 1'b0;
    pfail = 1'b0;
    clk_in_effect_in = 2'h0;
    ev = 8'h00;
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    srst_in = 1'b0;
    // Reset values of every register and control output
    rd(SCSB_ADDR_IF_CTRL, 8'h47);
    `CHK(ifo, 7'h47)
    `CHK(dgl_cyc, 32'(SCSB_DGL_SHORT_CYC))
    rd(SCSB_ADDR_CLK, 8'h00);
    `CHK(clk_select_out, 2'h0)
    rd(SCSB_ADDR_ERR_LO, 8'h00);
    rd(SCSB_ADDR_RAM_STATUS, 8'h00);
    // Interface control: all ones then all zeros, bit 7 must not stick
    wr(SCSB_ADDR_IF_CTRL, 8'hFF);
    `CHK(ifo, 7'h7F)
    rd(SCSB_ADDR_IF_CTRL, 8'h7F);
    @(negedge sys_clk_in);
    `CHK(dgl_cyc, 32'(SCSB_DGL_LONG_CYC))
    wr(SCSB_ADDR_IF_CTRL, 8'h00);
    `CHK(ifo, 7'h00)
    rd(SCSB_ADDR_IF_CTRL, 8'h00);
    @(negedge sys_clk_in);
    `CHK(dgl_cyc, 32'(SCSB_DGL_SHORT_CYC))
    for (int i = 0; i < 7; i++)
    begin
      wr(SCSB_ADDR_IF_CTRL, 8'(1 << i));
      `CHK(ifo, 7'(1 << i))
    end
    // Frozen clock enable leaves the register alone
    ce_in = 1'b0;
    wr(SCSB_ADDR_IF_CTRL, 8'h00);
    ce_in = 1'b1;
    rd(SCSB_ADDR_IF_CTRL, 8'h40);
    // Every frequency code through select and status fields
    for (int c = 0; c < 4; c++)
    begin
      wr(SCSB_ADDR_CLK, 8'(8'hCC | c));
      clk_in_effect_in = 2'(3 - c);
      @(negedge sys_clk_in);
      `CHK(clk_select_out, 2'(c))
      rd(SCSB_ADDR_CLK, {2'h0, 2'(3 - c), 2'h0, 2'(c)});
    end
    // Error flags accumulate one by one and ignore direct writes
    for (int i = 0; i < 8; i++)
    begin
      pulse_ev(8'(1 << i));
      rd(SCSB_ADDR_ERR_LO, 8'((2 << i) - 1));
    end
    wr(SCSB_ADDR_ERR_LO, 8'h00);
    rd(SCSB_ADDR_ERR_LO, 8'hFF);
    wr(SCSB_ADDR_ERR_HI, 8'h7F);
    rd(SCSB_ADDR_ERR_LO, 8'hFF);
    wr(SCSB_ADDR_ERR_HI, 8'h80);
    rd(SCSB_ADDR_ERR_LO, 8'h00);
    rd(SCSB_ADDR_ERR_HI, 8'h00);
    // Event arriving together with the clear must survive
    addr_in = SCSB_ADDR_ERR_HI;
    wdata_in = 8'h80;
    wr_in = 1'b1;
    ev = 8'h20;
    @(negedge sys_clk_in);
    wr_in = 1'b0;
    ev = 8'h00;
    @(negedge sys_clk_in);
    rd(SCSB_ADDR_ERR_LO, 8'h20);
    // Self-test status: failed data test, passed program test, restart
    ram_test(1'b0, 1'b1);
    rd(SCSB_ADDR_RAM_STATUS, 8'h03);
    ram_test(1'b1, 1'b0);
    rd(SCSB_ADDR_RAM_STATUS, 8'h13);
    ram_test(1'b1, 1'b1);
    rd(SCSB_ADDR_RAM_STATUS, 8'h33);
    dstart = 1'b1;
    @(negedge sys_clk_in);
    dstart = 1'b0;
    @(negedge sys_clk_in);
    rd(SCSB_ADDR_RAM_STATUS, 8'h30);
    wr(SCSB_ADDR_RAM_STATUS, 8'hFF);
    rd(SCSB_ADDR_RAM_STATUS, 8'h30);
    // Mid-run reset returns every register to its reset value
    srst_in = 1'b1;
    @(negedge sys_clk_in);
    srst_in = 1'b0;
    rd(SCSB_ADDR_ERR_LO, 8'h00);
    rd(SCSB_ADDR_IF_CTRL, 8'h47);
    rd(SCSB_ADDR_CLK, 8'h00);
    rd(SCSB_ADDR_RAM_STATUS, 8'h00);
    // Unmapped place reads zero and takes no write
    wr(32'h40000505, 8'hA5);
    rd(32'h40000505, 8'h00);
    give_verdict();
  end
endmodule // scsb_bank_tb_top
`undef CHK
`default_nettype wire
